/* File: lpm_pkg.sv */
// Package for the low-power mode controller: constants, types, register map
package lpm_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int CLK_MHZ = 200;
  // Base interval figure, milliseconds
  localparam int BASE_INTERVAL_MS = 500;
  localparam int BASE_INTERVAL_CYC = BASE_INTERVAL_MS * 1000 * CLK_MHZ;
  // Register indices
  localparam logic [ADDR_W-1:0] ADDR_TRIP_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_OPERATING_MODE_CONTROL = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_SAMPLE_CONFIG = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_CELL_TRIP = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_CHARGE_WAKE = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_LOW_CURRENT = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_PACK_WAKE = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_PACK_LOW = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h8;
  // trip_control field positions
  localparam int TC_CELL1_ENT = 0;
  localparam int TC_CELL2_ENT = 1;
  localparam int TC_CHARGE_WAKE = 2;
  localparam int TC_LOW_ENT = 3;
  localparam int TC_PACK_WAKE = 4;
  // operating_mode_control field positions
  localparam int OM_SLEEP_REQ = 0;
  localparam int OM_STORAGE_ENT = 1;
  localparam int OM_DIV_LSB = 4;
  localparam int DIV_W = 3;
  localparam logic [DATA_W-1:0] RESET_VALUE = 16'h0000;
  localparam int FILTER_ENTRY_CYC = 1000;
  localparam int FILTER_EXIT_CYC = 1000;

  typedef enum {MODE_RUN, MODE_SLEEP, MODE_WAKE_CONVERT, MODE_STORAGE} mode_t;

  typedef struct packed {
    logic signed [DATA_W-1:0] current;
    logic [DATA_W-1:0] cell1;
    logic [DATA_W-1:0] cell2;
    logic [DATA_W-1:0] pack;
  } meas_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage : lpm_pkg

/* File: bus_level_filter.sv */
// Filter that reports sustained low or high on both two-wire bus lines
`timescale 1ns/1ps
module bus_level_filter #(
  parameter int LOW_CYC = 1000,
  parameter int HIGH_CYC = 1000
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_line,
  input wire logic data_line,
  output logic both_low_held,
  output logic both_high_held
);
  localparam int MAXC = (LOW_CYC > HIGH_CYC) ? LOW_CYC : HIGH_CYC;
  localparam int CW = $clog2(MAXC + 1);
  logic [1:0] clk_sync;
  logic [1:0] data_sync;
  logic [CW-1:0] low_cnt;
  logic [CW-1:0] high_cnt;
  logic both_low;
  logic both_high;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_sync <= 2'h3;
      data_sync <= 2'h3;
    end else begin
      clk_sync <= {clk_sync[0], clk_line};
      data_sync <= {data_sync[0], data_line};
    end
  end

  assign both_low = !clk_sync[1] && !data_sync[1];
  assign both_high = clk_sync[1] && data_sync[1];

  // Counters restart on any break in the level
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt <= '0;
      both_low_held <= 1'b0;
    end else if (!both_low) begin
      low_cnt <= '0;
      both_low_held <= 1'b0;
    end else if (low_cnt < CW'(LOW_CYC)) begin
      low_cnt <= low_cnt + CW'(1);
    end else begin
      both_low_held <= 1'b1; // R13 R17
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      high_cnt <= '0;
      both_high_held <= 1'b0;
    end else if (!both_high) begin
      high_cnt <= '0;
      both_high_held <= 1'b0;
    end else if (high_cnt < CW'(HIGH_CYC)) begin
      high_cnt <= high_cnt + CW'(1);
    end else begin
      both_high_held <= 1'b1; // R14 R17
    end
  end
endmodule : bus_level_filter

/* File: low_power_mode_control.sv */
// Low-power mode controller: run, sleep-sample and storage sleep sequencing
//
// Notes on behaviour
// (R1) Sleep powers analog off; wake runs one set
// (R2) Sleep intervals timed by separate RC oscillator
// (R3) Low cell with its enable enters sleep-sample
// (R4) Charge wake above threshold blocks sleep entry
// (R5) Host sleep request bit enters sleep-sample
// (R6) Low current with enable enters sleep-sample
// (R7) Interval is 0.5 s times 2 to the sum of two exponents
// (R8) Clearing request or enabled wake exits sleep
// (R9) Charge current above threshold wakes when enabled
// (R10) Pack voltage above threshold wakes when enabled
// (R11) Storage: no measuring, bus ignored, memory lost
// (R12) Storage armed by bit or low pack
// (R13) Armed: both lines held low enters storage
// (R14) Both lines held high exits storage
// (R15) Run held when no low-power mode active
// (R16) Sample exponent is three bits, 0 to 7
// (R17) Entry and exit times are filter parameters
`timescale 1ns/1ps
module low_power_mode_control
  import lpm_pkg::*;
#(
  parameter int BASE_CYC = BASE_INTERVAL_CYC,
  parameter int ENTRY_CYC = FILTER_ENTRY_CYC,
  parameter int EXIT_CYC = FILTER_EXIT_CYC
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire lpm_pkg::reg_req_t reg_req,
  output logic [lpm_pkg::DATA_W-1:0] reg_rdata,
  input wire lpm_pkg::meas_t meas,
  input wire logic meas_valid,
  input wire logic power_good,
  input wire logic sleep_osc_tick,
  input wire logic clk_line_in,
  input wire logic data_line_in,
  output logic analog_enable,
  output logic convert_start,
  output logic accumulate_enable,
  output logic bus_enable,
  output logic volatile_clear,
  output logic [1:0] mode_code
);
  mode_t mode;
  logic [DATA_W-1:0] trip_control;
  logic [DATA_W-1:0] operating_mode_control;
  logic [DATA_W-1:0] sample_config;
  logic [DATA_W-1:0] cell_voltage_trip_level;
  logic [DATA_W-1:0] charge_wake_threshold;
  logic [DATA_W-1:0] low_current_threshold;
  logic [DATA_W-1:0] pack_voltage_wake_threshold;
  logic [DATA_W-1:0] pack_low_storage_threshold;
  logic [1:0] tick_sync;
  logic tick_prev;
  logic tick_pulse;
  logic [1:0] pg_sync;
  logic both_low_held;
  logic both_high_held;
  logic storage_armed;
  logic entry_cond;
  logic wake_cond;
  logic sleep_req;
  logic [DIV_W-1:0] sample_divider_exponent;
  logic [DIV_W-1:0] sleep_divider_exponent;
  logic [31:0] tick_cnt;
  logic [31:0] interval_ticks;
  logic [DATA_W-1:0] status_word;
  logic convert_pending;

  bus_level_filter #(
    .LOW_CYC(ENTRY_CYC),
    .HIGH_CYC(EXIT_CYC)
  ) u_filter (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clk_line(clk_line_in),
    .data_line(data_line_in),
    .both_low_held(both_low_held),
    .both_high_held(both_high_held)
  );

  // Sleep oscillator tick and power-good arrive asynchronously
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_sync <= 2'h0;
      tick_prev <= 1'b0;
      pg_sync <= 2'h0;
    end else begin
      tick_sync <= {tick_sync[0], sleep_osc_tick};
      tick_prev <= tick_sync[1];
      pg_sync <= {pg_sync[0], power_good};
    end
  end
  assign tick_pulse = tick_sync[1] && !tick_prev; // R2

  assign sleep_req = operating_mode_control[OM_SLEEP_REQ];
  assign sleep_divider_exponent = operating_mode_control[OM_DIV_LSB +: DIV_W];
  assign sample_divider_exponent = sample_config[DIV_W-1:0]; // R16

  // One sleep tick equals the base half-second; interval in ticks
  assign interval_ticks = 32'(1) << (32'(sample_divider_exponent) + 32'(sleep_divider_exponent)); // R7

  assign entry_cond = sleep_req // R5
    || (trip_control[TC_CELL1_ENT] && meas.cell1 < cell_voltage_trip_level) // R3
    || (trip_control[TC_CELL2_ENT] && meas.cell2 < cell_voltage_trip_level) // R3
    || (trip_control[TC_LOW_ENT] && $signed(meas.current) < $signed(low_current_threshold)); // R6

  assign wake_cond = (trip_control[TC_CHARGE_WAKE]
      && $signed(meas.current) > $signed(charge_wake_threshold)) // R9 R4
    || (trip_control[TC_PACK_WAKE] && meas.pack > pack_voltage_wake_threshold); // R10

  assign storage_armed = operating_mode_control[OM_STORAGE_ENT]
    || meas.pack < pack_low_storage_threshold; // R12

  // Mode sequencer
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode <= MODE_RUN;
      tick_cnt <= '0;
    end else begin
      case (mode)
        MODE_RUN: begin
          tick_cnt <= '0;
          if (storage_armed && both_low_held) begin
            mode <= MODE_STORAGE; // R13
          end else if (pg_sync[1] && entry_cond && !wake_cond) begin
            mode <= MODE_SLEEP; // R3 R4 R5 R6
          end else begin
            mode <= MODE_RUN; // R15
          end
        end
        MODE_SLEEP: begin
          if (storage_armed && both_low_held) begin
            mode <= MODE_STORAGE; // R13
          end else if (!sleep_req && !entry_cond) begin
            mode <= MODE_RUN; // R8
          end else if (wake_cond) begin
            mode <= MODE_RUN; // R8 R9 R10
          end else if (tick_pulse) begin
            if (tick_cnt + 32'(1) >= interval_ticks) begin
              tick_cnt <= '0;
              mode <= MODE_WAKE_CONVERT; // R1 R7
            end else begin
              tick_cnt <= tick_cnt + 32'(1);
            end
          end
        end
        MODE_WAKE_CONVERT: begin
          if (meas_valid && !convert_pending) begin
            if (wake_cond || (!sleep_req && !entry_cond)) begin
              mode <= MODE_RUN; // R8
            end else begin
              mode <= MODE_SLEEP; // R1
            end
          end
        end
        MODE_STORAGE: begin
          if (both_high_held) begin
            mode <= MODE_RUN; // R14
          end
        end
        default: begin
          mode <= MODE_RUN;
        end
      endcase
    end
  end

  // One conversion start per wake
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      convert_pending <= 1'b0;
      convert_start <= 1'b0;
    end else begin
      convert_start <= 1'b0;
      if (mode == MODE_SLEEP && tick_pulse && tick_cnt + 32'(1) >= interval_ticks
          && !wake_cond && (sleep_req || entry_cond) && !(storage_armed && both_low_held)) begin
        convert_pending <= 1'b1;
      end else if (mode == MODE_WAKE_CONVERT && convert_pending) begin
        convert_pending <= 1'b0;
        convert_start <= 1'b1; // R1
      end
    end
  end

  // Outputs derived from mode
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      analog_enable <= 1'b1;
      accumulate_enable <= 1'b1;
      bus_enable <= 1'b1;
      volatile_clear <= 1'b0;
      mode_code <= 2'h0;
    end else begin
      analog_enable <= (mode == MODE_RUN) || (mode == MODE_WAKE_CONVERT); // R1 R11
      accumulate_enable <= (mode != MODE_STORAGE); // R11
      bus_enable <= (mode != MODE_STORAGE); // R11
      volatile_clear <= (mode == MODE_STORAGE); // R11
      case (mode)
        MODE_RUN: mode_code <= 2'h0;
        MODE_SLEEP: mode_code <= 2'h1;
        MODE_WAKE_CONVERT: mode_code <= 2'h2;
        MODE_STORAGE: mode_code <= 2'h3;
        default: mode_code <= 2'h0;
      endcase
    end
  end

  // Register writes; bus ignored and contents lost in storage
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      trip_control <= RESET_VALUE;
      operating_mode_control <= RESET_VALUE;
      sample_config <= RESET_VALUE;
      cell_voltage_trip_level <= RESET_VALUE;
      charge_wake_threshold <= RESET_VALUE;
      low_current_threshold <= RESET_VALUE;
      pack_voltage_wake_threshold <= RESET_VALUE;
      pack_low_storage_threshold <= RESET_VALUE;
    end else if (mode == MODE_STORAGE) begin
      trip_control <= RESET_VALUE; // R11
      operating_mode_control <= RESET_VALUE;
      sample_config <= RESET_VALUE;
      cell_voltage_trip_level <= RESET_VALUE;
      charge_wake_threshold <= RESET_VALUE;
      low_current_threshold <= RESET_VALUE;
      pack_voltage_wake_threshold <= RESET_VALUE;
      pack_low_storage_threshold <= RESET_VALUE;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        ADDR_TRIP_CONTROL: trip_control <= {11'h000, reg_req.wdata[4:0]};
        ADDR_OPERATING_MODE_CONTROL: operating_mode_control <= {9'h000, reg_req.wdata[6:4], 2'h0, reg_req.wdata[1:0]};
        ADDR_SAMPLE_CONFIG: sample_config <= {13'h0000, reg_req.wdata[DIV_W-1:0]}; // R16
        ADDR_CELL_TRIP: cell_voltage_trip_level <= reg_req.wdata;
        ADDR_CHARGE_WAKE: charge_wake_threshold <= reg_req.wdata;
        ADDR_LOW_CURRENT: low_current_threshold <= reg_req.wdata;
        ADDR_PACK_WAKE: pack_voltage_wake_threshold <= reg_req.wdata;
        ADDR_PACK_LOW: pack_low_storage_threshold <= reg_req.wdata;
        default: begin
        end
      endcase
    end
  end

  assign status_word = {11'h000, storage_armed, wake_cond, entry_cond, mode_code};

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_req.rd && mode != MODE_STORAGE) begin
      case (reg_req.addr)
        ADDR_TRIP_CONTROL: reg_rdata <= trip_control;
        ADDR_OPERATING_MODE_CONTROL: reg_rdata <= operating_mode_control;
        ADDR_SAMPLE_CONFIG: reg_rdata <= sample_config;
        ADDR_CELL_TRIP: reg_rdata <= cell_voltage_trip_level;
        ADDR_CHARGE_WAKE: reg_rdata <= charge_wake_threshold;
        ADDR_LOW_CURRENT: reg_rdata <= low_current_threshold;
        ADDR_PACK_WAKE: reg_rdata <= pack_voltage_wake_threshold;
        ADDR_PACK_LOW: reg_rdata <= pack_low_storage_threshold;
        ADDR_STATUS: reg_rdata <= status_word;
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule : low_power_mode_control

/* File: lpm_properties.sv */
// Checker: mode sequencing properties seen at the controller ports
`timescale 1ns/1ps
module lpm_properties
  import lpm_pkg::*;
#(
  parameter int ENTRY_CYC = FILTER_ENTRY_CYC,
  parameter int EXIT_CYC = FILTER_EXIT_CYC
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [lpm_pkg::DATA_W-1:0] reg_rdata,
  input wire logic clk_line_in,
  input wire logic data_line_in,
  input wire logic analog_enable,
  input wire logic convert_start,
  input wire logic accumulate_enable,
  input wire logic bus_enable,
  input wire logic volatile_clear,
  input wire logic [1:0] mode_code
);
  logic [15:0] low_cnt;
  logic [15:0] high_cnt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Consecutive cycles with both lines low
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt <= 16'h0000;
    end else if (clk_line_in || data_line_in) begin
      low_cnt <= 16'h0000;
    end else if (low_cnt != 16'hFFFF) begin
      low_cnt <= low_cnt + 16'h0001;
    end
  end
  // Consecutive cycles with both lines high
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      high_cnt <= 16'h0000;
    end else if (!clk_line_in || !data_line_in) begin
      high_cnt <= 16'h0000;
    end else if (high_cnt != 16'hFFFF) begin
      high_cnt <= high_cnt + 16'h0001;
    end
  end
  AST_SLEEP_ANALOG_OFF: assert property (mode_code == 2'h1 |-> !analog_enable)
    else $error("analog on while asleep");
  AST_CONVERT_PULSE: assert property (convert_start |=> !convert_start)
    else $error("convert start longer than one cycle");
  AST_CONVERT_AT_WAKE: assert property ($rose(mode_code == 2'h2) |-> ##[0:2] convert_start)
    else $error("wake without convert start");
  AST_WAKE_FROM_SLEEP: assert property ($changed(mode_code) && mode_code == 2'h2 |-> $past(mode_code) == 2'h1)
    else $error("wake convert not entered from sleep");
  AST_STORAGE_OUTPUTS: assert property (mode_code == 2'h3 |-> !bus_enable && !accumulate_enable && !analog_enable && volatile_clear)
    else $error("storage outputs wrong");
  AST_STORAGE_READ_ZERO: assert property (mode_code == 2'h3 && $past(mode_code) == 2'h3 |-> reg_rdata == 16'h0000)
    else $error("read data in storage");
  AST_STORAGE_ENTRY_LOW: assert property ($rose(mode_code == 2'h3) |-> low_cnt >= ENTRY_CYC)
    else $error("storage entered before low time");
  AST_STORAGE_EXIT_HIGH: assert property ($fell(mode_code == 2'h3) |-> high_cnt >= EXIT_CYC)
    else $error("storage left before high time");
  AST_STORAGE_EXIT_RUN: assert property ($past(mode_code) == 2'h3 && mode_code != 2'h3 |-> mode_code == 2'h0)
    else $error("storage not left to run");
  AST_RUN_OUTPUTS: assert property (mode_code == 2'h0 |-> analog_enable && bus_enable && accumulate_enable && !volatile_clear)
    else $error("run outputs wrong");
endmodule : lpm_properties

bind low_power_mode_control lpm_properties #(.ENTRY_CYC(ENTRY_CYC), .EXIT_CYC(EXIT_CYC)) lpm_properties_i (
  .core_clk(core_clk), .rst_b(rst_b), .reg_rdata(reg_rdata), .clk_line_in(clk_line_in),
  .data_line_in(data_line_in), .analog_enable(analog_enable), .convert_start(convert_start),
  .accumulate_enable(accumulate_enable), .bus_enable(bus_enable), .volatile_clear(volatile_clear),
  .mode_code(mode_code));

/* File: host_line_model.sv */
// Host-side model of the two-wire bus lines seen by the controller
`timescale 1ns/1ps
module host_line_model (
  input wire logic [1:0] hold_low,
  output logic clk_line,
  output logic data_line
);
  // Released lines float up through the bus pull-ups
  assign clk_line = hold_low[1] ? 1'b0 : 1'b1;
  assign data_line = hold_low[0] ? 1'b0 : 1'b1;
endmodule : host_line_model

/* File: tb_low_power_mode_control.sv */
// Testbench: self-checking scenarios for the low-power mode controller
`timescale 1ns/1ps
module tb_low_power_mode_control;
  import lpm_pkg::*;
  localparam meas_t MEAS_IDLE = '{current: 16'sh0000, cell1: 16'h0FA0, cell2: 16'h0FA0, pack: 16'h0BB8};
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  reg_req_t req = '0;
  meas_t meas = MEAS_IDLE;
  logic meas_valid = 1'b0;
  logic power_good = 1'b1;
  logic tick = 1'b0;
  logic [1:0] hold = 2'b00;
  logic clk_line;
  logic data_line;
  logic [DATA_W-1:0] rdata;
  logic analog_enable, convert_start, accumulate_enable, bus_enable, volatile_clear;
  logic [1:0] mode_code;
  int n_fail = 0;
  int n_tests = 0;
  int n_conv = 0;
  always #2.5 core_clk = ~core_clk;
  // Convert start pulses seen
  always @(posedge core_clk) begin
    if (convert_start === 1'b1) begin
      n_conv++;
    end
  end
  host_line_model host_line_model_i (.hold_low(hold), .clk_line(clk_line), .data_line(data_line));
  low_power_mode_control #(.ENTRY_CYC(8), .EXIT_CYC(8)) low_power_mode_control_i (
    .core_clk(core_clk), .rst_b(rst_b), .reg_req(req), .reg_rdata(rdata), .meas(meas),
    .meas_valid(meas_valid), .power_good(power_good), .sleep_osc_tick(tick), .clk_line_in(clk_line),
    .data_line_in(data_line), .analog_enable(analog_enable), .convert_start(convert_start),
    .accumulate_enable(accumulate_enable), .bus_enable(bus_enable), .volatile_clear(volatile_clear),
    .mode_code(mode_code));
  task automatic wrap_up;
    $display("counts: %0d compared, %0d mismatched", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : idle
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input string what, input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask : rd_chk
  task automatic wait_mode(input logic [1:0] m);
    int i;
    for (i = 0; i < 3000 && mode_code !== m; i++) begin
      idle(1);
    end
    chk("mode_code", {14'h0000, m}, {14'h0000, mode_code});
    if (mode_code !== m) begin
      wrap_up();
    end
  endtask : wait_mode
  task automatic tick_pulse;
    @(posedge core_clk) tick <= 1'b1;
    repeat (4) @(posedge core_clk);
    tick <= 1'b0;
    idle(6);
  endtask : tick_pulse
  task automatic t_reset;
    chk("mode_code", 16'h0000, {14'h0000, mode_code});
    chk("run enables", 16'h000E, {12'h000, analog_enable, bus_enable, accumulate_enable, volatile_clear});
    rd_chk("reset operating_mode_control", ADDR_OPERATING_MODE_CONTROL, RESET_VALUE);
    wr(ADDR_TRIP_CONTROL, 16'h001F);
    rd_chk("trip_control", ADDR_TRIP_CONTROL, 16'h001F);
    rd_chk("unmapped", 4'hF, 16'h0000);
    wr(ADDR_TRIP_CONTROL, 16'h0000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_request;
    int n;
    wr(ADDR_SAMPLE_CONFIG, 16'h0001);
    @(posedge core_clk) power_good <= 1'b0;
    wr(ADDR_OPERATING_MODE_CONTROL, 16'h0011);
    idle(10);
    chk("no power", 16'h0000, {14'h0000, mode_code});
    @(posedge core_clk) power_good <= 1'b1;
    wait_mode(2'h1);
    chk("analog asleep", 16'h0000, {15'h0000, analog_enable});
    n = 0;
    while (n < 8 && mode_code !== 2'h2) begin
      tick_pulse();
      n++;
    end
    chk("ticks to wake", 16'h0004, n[15:0]);
    @(posedge core_clk) meas_valid <= 1'b1;
    @(posedge core_clk) meas_valid <= 1'b0;
    wait_mode(2'h1);
    chk("convert starts", 16'h0001, n_conv[15:0]);
    wr(ADDR_OPERATING_MODE_CONTROL, 16'h0000);
    wait_mode(2'h0);
    wr(ADDR_SAMPLE_CONFIG, 16'h0000);
    $display("test request done");
  endtask : t_request
  task automatic t_cell;
    wr(ADDR_CELL_TRIP, 16'h0BB8);
    wr(ADDR_CHARGE_WAKE, 16'h00C8);
    wr(ADDR_TRIP_CONTROL, 16'h0006);
    @(posedge core_clk) meas.current <= 16'sh01F4;
    @(posedge core_clk) meas.cell2 <= 16'h07D0;
    idle(40);
    chk("mode blocked", 16'h0000, {14'h0000, mode_code});
    @(posedge core_clk) meas.current <= 16'sh0000;
    wait_mode(2'h1);
    @(posedge core_clk) meas.current <= 16'sh01F4;
    wait_mode(2'h0);
    wr(ADDR_TRIP_CONTROL, 16'h0000);
    @(posedge core_clk) meas <= MEAS_IDLE;
    $display("test cell done");
  endtask : t_cell
  task automatic t_pack;
    wr(ADDR_LOW_CURRENT, 16'h0064);
    wr(ADDR_PACK_WAKE, 16'h0FA0);
    @(posedge core_clk) meas.current <= 16'sh0032;
    wr(ADDR_TRIP_CONTROL, 16'h0018);
    wait_mode(2'h1);
    @(posedge core_clk) meas.pack <= 16'h1388;
    wait_mode(2'h0);
    wr(ADDR_TRIP_CONTROL, 16'h0000);
    @(posedge core_clk) meas <= MEAS_IDLE;
    $display("test pack done");
  endtask : t_pack
  task automatic storage_cycle;
    @(posedge core_clk) hold <= 2'b11;
    wait_mode(2'h3);
    chk("storage outputs", 16'h0001, {12'h000, analog_enable, bus_enable, accumulate_enable, volatile_clear});
    wr(ADDR_TRIP_CONTROL, 16'h001F);
    rd_chk("storage read", ADDR_TRIP_CONTROL, 16'h0000);
    @(posedge core_clk) hold <= 2'b00;
    wait_mode(2'h0);
    rd_chk("operating_mode_control lost", ADDR_OPERATING_MODE_CONTROL, 16'h0000);
  endtask : storage_cycle
  task automatic t_storage;
    @(posedge core_clk) hold <= 2'b11;
    idle(20);
    chk("unarmed", 16'h0000, {14'h0000, mode_code});
    @(posedge core_clk) hold <= 2'b00;
    idle(10);
    wr(ADDR_OPERATING_MODE_CONTROL, 16'h0002);
    @(posedge core_clk) hold <= 2'b01;
    idle(20);
    @(posedge core_clk) hold <= 2'b11;
    idle(4);
    @(posedge core_clk) hold <= 2'b00;
    idle(10);
    chk("short low", 16'h0000, {14'h0000, mode_code});
    storage_cycle();
    wr(ADDR_PACK_LOW, 16'h0FA0);
    storage_cycle();
    $display("test storage done");
  endtask : t_storage
  initial begin
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    idle(2);
    t_reset();
    t_request();
    t_cell();
    t_pack();
    t_storage();
    wrap_up();
  end
endmodule : tb_low_power_mode_control
